// [core/mabp_device.sv]
`timescale 1ns/1ns
`default_nettype none
module mabp_device (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// Bus pins
	mabp_if.device                bus,
	// Configuration
	input  wire mabp_pkg::mabp_mode_t mode,
	input  wire mabp_pkg::mabp_c0_t   c0_kind,
	input  wire logic             ale_high,
	// Logic array side
	input  wire logic             block_select,
	input  wire logic [7:0]       read_low,
	input  wire logic [7:0]       read_high,
	input  wire logic             flash_busy_in,
	output logic [19:0]           array_address,
	output logic                  array_read,
	output logic                  array_write,
	output logic                  array_fetch_n,
	output logic                  array_generic,
	output logic [7:0]            write_low,
	output logic [7:0]            write_high,
	output logic                  write_strobe,
	output logic                  flash_abort
);
	typedef struct packed {
		logic [7:0]  s1_low;
		logic [7:0]  s2_low;
		logic [7:0]  s1_high;
		logic [7:0]  s2_high;
		logic [3:0]  s1_ctl;
		logic [3:0]  s2_ctl;
		logic        wr_d;
		logic [19:0] addr;
		logic        rd;
		logic        wr;
		logic        fetch_n;
		logic        generic;
		logic [7:0]  wlow;
		logic [7:0]  whigh;
		logic        wstb;
		logic [7:0]  dlow;
		logic [7:0]  dhigh;
		logic        oe_low_n;
		logic        oe_high_n;
		logic        abort;
	} mabp_dev_t;

	mabp_dev_t st;
	mabp_dev_t next_st;
	logic      strobe_on;
	logic      rd_now;
	logic      wr_now;
	logic      drive_low;
	logic      drive_high;

	always_comb
	begin
		next_st = st;
		next_st.s1_low = bus.low_byte_bus_port;
		next_st.s2_low = st.s1_low;
		next_st.s1_high = bus.high_byte_bus_port;
		next_st.s2_high = st.s1_high;
		next_st.s1_ctl = {bus.address_strobe, bus.control_input_third,
			bus.control_input_second, bus.control_input_first};
		next_st.s2_ctl = st.s1_ctl;
		// Strobe polarity: high for latch strobe, low for address strobe.
		strobe_on = st.s2_ctl[3] == ale_high;
		// A read/write line needs the data strobe to qualify it.
		case (c0_kind)
			mabp_pkg::MABP_C0_RW:
			begin
				rd_now = st.s2_ctl[0] && !st.s2_ctl[1];
				wr_now = !st.s2_ctl[0] && !st.s2_ctl[1];
			end
			mabp_pkg::MABP_C0_WR_N:
			begin
				rd_now = !st.s2_ctl[1];
				wr_now = !st.s2_ctl[0];
			end
			default:
			begin
				// An unknown wiring is treated as an idle bus.
				rd_now = 1'b0;
				wr_now = 1'b0;
			end
		endcase
		if (strobe_on)
		begin
			// Transparent while strobe active, held afterwards.
			case (mode)
				mabp_pkg::MABP_BURST:
					next_st.addr = {st.s2_high, st.s2_low, 4'h0};
				mabp_pkg::MABP_MUX,
				mabp_pkg::MABP_NOMUX,
				mabp_pkg::MABP_PAGE:
					next_st.addr = {4'h0, st.s2_high, st.s2_low};
				default:
					next_st.addr = st.addr;
			endcase
		end
		next_st.rd = rd_now;
		next_st.wr = wr_now;
		next_st.fetch_n = st.s2_ctl[2];
		next_st.generic = st.s2_ctl[2];
		next_st.wr_d = wr_now;
		next_st.wstb = 1'b0;
		// Data is taken at the end of the write pulse so it has settled.
		if (st.wr_d && !wr_now)
		begin
			next_st.wstb = 1'b1;
			next_st.wlow = st.s2_low;
			next_st.whigh = (mode == mabp_pkg::MABP_PAGE) ?
				st.s2_high : 8'h00;
		end
		next_st.dlow = read_low;
		next_st.dhigh = read_high;
		// Drivers wait for the strobe to drop, so outside no-mux mode a read never fights the
		// address that the host is still presenting.
		drive_low = rd_now && block_select && !strobe_on;
		drive_high = drive_low && mode == mabp_pkg::MABP_PAGE;
		next_st.oe_low_n = !drive_low;
		next_st.oe_high_n = !drive_high;
		// Abort stays up until the flash engine reports idle.
		next_st.abort = flash_busy_in && st.abort;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st.s1_low <= mabp_pkg::DATA_RESET;
			st.s2_low <= mabp_pkg::DATA_RESET;
			st.s1_high <= mabp_pkg::DATA_RESET;
			st.s2_high <= mabp_pkg::DATA_RESET;
			// A latch strobe idles low; an active-low strobe sees two false
			// strobe cycles after reset, which only reload the cleared address.
			st.s1_ctl <= 4'h7;
			st.s2_ctl <= 4'h7;
			st.wr_d <= 1'b0;
			st.addr <= 20'h00000;
			st.rd <= 1'b0;
			st.wr <= 1'b0;
			st.fetch_n <= 1'b1;
			st.generic <= 1'b1;
			st.wlow <= mabp_pkg::DATA_RESET;
			st.whigh <= mabp_pkg::DATA_RESET;
			st.wstb <= 1'b0;
			st.dlow <= mabp_pkg::DATA_RESET;
			st.dhigh <= mabp_pkg::DATA_RESET;
			st.oe_low_n <= 1'b1;
			st.oe_high_n <= 1'b1;
			// Abort stays high across reset; flash engine reads it.
			st.abort <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign bus.dev_low_out = st.dlow;
	assign bus.dev_high_out = st.dhigh;
	assign bus.dev_low_oe_n = st.oe_low_n;
	assign bus.dev_high_oe_n = st.oe_high_n;
	assign array_address = st.addr;
	assign array_read = st.rd;
	assign array_write = st.wr;
	assign array_fetch_n = st.fetch_n;
	assign array_generic = st.generic;
	assign write_low = st.wlow;
	assign write_high = st.whigh;
	assign write_strobe = st.wstb;
	assign flash_abort = st.abort;
endmodule // mabp_device
`default_nettype wire

// [core/mabp_host.sv]
`timescale 1ns/1ns
`default_nettype none
module mabp_host (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// Bus pins
	mabp_if.host                  bus,
	// Configuration
	input  wire mabp_pkg::mabp_mode_t mode,
	input  wire logic             fetch_as_read,
	// Request
	input  wire logic             req,
	input  wire logic             req_write,
	input  wire logic [19:0]      req_addr,
	input  wire logic [15:0]      req_data,
	output logic                  busy,
	output logic                  done,
	output logic [15:0]           rdata
);
	typedef struct packed {
		mabp_pkg::mabp_hstate_t state;
		logic [1:0]  cnt;
		logic        write;
		logic [19:0] addr;
		logic [15:0] wdata;
		logic [7:0]  lo;
		logic        lo_oe_n;
		logic [7:0]  hi;
		logic        hi_oe_n;
		logic        ale;
		logic        c0;
		logic        c1;
		logic        c2;
		logic        busy;
		logic        done;
		logic [15:0] rdata;
	} mabp_host_t;

	mabp_host_t st;
	mabp_host_t next_st;
	logic       muxed;

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		muxed = mode != mabp_pkg::MABP_NOMUX;
		case (st.state)
			mabp_pkg::MABP_H_IDLE:
				if (req)
				begin
					next_st.write = req_write;
					next_st.addr = req_addr;
					next_st.wdata = req_data;
					next_st.busy = 1'b1;
					next_st.ale = 1'b1;
					next_st.cnt = 2'h0;
					next_st.lo_oe_n = 1'b0;
					next_st.hi_oe_n = 1'b0;
					if (mode == mabp_pkg::MABP_BURST)
					begin
						next_st.lo = req_addr[11:4];
						next_st.hi = req_addr[19:12];
					end
					else
					begin
						next_st.lo = req_addr[7:0];
						next_st.hi = req_addr[15:8];
					end
					next_st.state = mabp_pkg::MABP_H_ADDR;
				end
			mabp_pkg::MABP_H_ADDR:
			begin
				next_st.cnt = st.cnt + 2'h1;
				if (st.cnt == 2'(mabp_pkg::STROBE_CYCLES))
				begin
					next_st.ale = 1'b0;
					next_st.state = mabp_pkg::MABP_H_HOLD;
				end
			end
			mabp_pkg::MABP_H_HOLD:
			begin
				next_st.cnt = 2'h0;
				if (muxed)
				begin
					next_st.lo_oe_n = !st.write;
					next_st.lo = st.wdata[7:0];
				end
				if (mode == mabp_pkg::MABP_PAGE)
				begin
					next_st.hi_oe_n = !st.write;
					next_st.hi = st.wdata[15:8];
				end
				if (st.write)
					next_st.c0 = 1'b0;
				else if (fetch_as_read)
					next_st.c1 = 1'b0;
				else
				begin
					// A host with its own fetch strobe flags the read on the
					// third input as well.
					next_st.c1 = 1'b0;
					next_st.c2 = 1'b0;
				end
				next_st.state = mabp_pkg::MABP_H_DATA;
			end
			mabp_pkg::MABP_H_DATA:
			begin
				next_st.cnt = st.cnt + 2'h1;
				if (st.cnt == 2'(mabp_pkg::DATA_CYCLES))
				begin
					next_st.rdata = {bus.high_byte_bus_port,
						bus.low_byte_bus_port};
					next_st.c0 = 1'b1;
					next_st.c1 = 1'b1;
					next_st.c2 = 1'b1;
					next_st.state = mabp_pkg::MABP_H_END;
				end
			end
			mabp_pkg::MABP_H_END:
			begin
				next_st.lo_oe_n = 1'b1;
				next_st.hi_oe_n = 1'b1;
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.state = mabp_pkg::MABP_H_IDLE;
			end
			default:
				next_st.state = mabp_pkg::MABP_H_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.state <= mabp_pkg::MABP_H_IDLE;
			st.lo_oe_n <= 1'b1;
			st.hi_oe_n <= 1'b1;
			st.c0 <= 1'b1;
			st.c1 <= 1'b1;
			st.c2 <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign bus.low_out = st.lo;
	assign bus.low_oe_n = st.lo_oe_n;
	assign bus.high_out = st.hi;
	assign bus.high_oe_n = st.hi_oe_n;
	assign bus.address_strobe = st.ale;
	assign bus.control_input_first = st.c0;
	assign bus.control_input_second = st.c1;
	assign bus.control_input_third = st.c2;
	assign busy = st.busy;
	assign done = st.done;
	assign rdata = st.rdata;
endmodule // mabp_host
`default_nettype wire

// [core/mabp_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface mabp_if;
	// Host side drives.
	logic [7:0] low_out;
	logic       low_oe_n;
	logic [7:0] high_out;
	logic       high_oe_n;
	logic       address_strobe;
	logic       control_input_first;
	logic       control_input_second;
	logic       control_input_third;
	// Device side drives.
	logic [7:0] dev_low_out;
	logic [7:0] dev_high_out;
	logic       dev_low_oe_n;
	logic       dev_high_oe_n;
	// Resolved wire levels; undriven reads as zero.
	logic [7:0] low_byte_bus_port;
	logic [7:0] high_byte_bus_port;

	assign low_byte_bus_port = !low_oe_n ? low_out :
		(!dev_low_oe_n ? dev_low_out : 8'h00);
	assign high_byte_bus_port = !high_oe_n ? high_out :
		(!dev_high_oe_n ? dev_high_out : 8'h00);

	modport device (
		input  low_byte_bus_port,
		input  high_byte_bus_port,
		input  address_strobe,
		input  control_input_first,
		input  control_input_second,
		input  control_input_third,
		output dev_low_out,
		output dev_high_out,
		output dev_low_oe_n,
		output dev_high_oe_n
	);
	modport host (
		input  low_byte_bus_port,
		input  high_byte_bus_port,
		output low_out,
		output low_oe_n,
		output high_out,
		output high_oe_n,
		output address_strobe,
		output control_input_first,
		output control_input_second,
		output control_input_third
	);
endinterface
`default_nettype wire

// [core/mabp_pkg.sv]
// Overview of operation
// - Host drives low port with low address
// - Host drives high port with A8-A15
// - Burst mode: A4-A11/data low, A12-A19 high
// - Page mode: high port carries data too
// - Address strobe captures the address
// - Drive data only on read and select
// - Latched address feeds decode arrays
// - First control: write strobe or read/write
// - Second control: read, data strobe, fetch
// - Wide hosts wire fetch line as read
// - Third control: fetch strobe or generic
// - Reset clears ports, cells, config registers
// - System holds reset low at power-up
// - Reset aborts flash program or erase
package mabp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int BURST_W = 20;

	// Bus styles a host may use.
	typedef enum logic [3:0] {
		MABP_MUX   = 4'h1,
		MABP_NOMUX = 4'h2,
		MABP_PAGE  = 4'h4,
		MABP_BURST = 4'h8
	} mabp_mode_t;

	// First control input meaning.
	typedef enum logic [1:0] {
		MABP_C0_WR_N = 2'h1,
		MABP_C0_RW   = 2'h2
	} mabp_c0_t;

	// Host transaction states.
	typedef enum logic [4:0] {
		MABP_H_IDLE  = 5'h01,
		MABP_H_ADDR  = 5'h02,
		MABP_H_HOLD  = 5'h04,
		MABP_H_DATA  = 5'h08,
		MABP_H_END   = 5'h10
	} mabp_hstate_t;

	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int STROBE_CYCLES = 2;
	localparam int DATA_CYCLES = 3;
endpackage

// [verification/mabp_props.sv]
`timescale 1ns/1ns
`default_nettype none
module mabp_props (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       resetn,
	// Bus signals
	input wire logic [7:0] high_byte_bus_port,
	input wire logic       low_oe_n,
	input wire logic       address_strobe,
	input wire logic       control_input_first,
	input wire logic       control_input_second,
	input wire logic       dev_low_oe_n,
	input wire logic       dev_high_oe_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	strobe_quiet_a: assert property (
		address_strobe |-> dev_low_oe_n && dev_high_oe_n)
		else $error("Device drove during strobe.");
	low_read_only_a: assert property (
		$fell(dev_low_oe_n) |-> !control_input_second)
		else $error("Low drive without read.");
	high_read_only_a: assert property (
		$fell(dev_high_oe_n) |-> !control_input_second)
		else $error("High drive without read.");
	dev_reset_idle_a: assert property (
		$rose(resetn) |-> dev_low_oe_n && dev_high_oe_n)
		else $error("Device drives after reset.");
	host_reset_idle_a: assert property (
		$rose(resetn) |-> low_oe_n && !address_strobe)
		else $error("Host not idle after reset.");
	strobe_bound_a: assert property (
		$rose(address_strobe) |->
		address_strobe[*2] ##[1:5] !address_strobe)
		else $error("Strobe width wrong.");
	addr_steady_a: assert property (
		address_strobe && $past(address_strobe) |->
		$stable(high_byte_bus_port))
		else $error("High address moved in strobe.");
	ctrl_idle_a: assert property (
		address_strobe |-> control_input_first && control_input_second)
		else $error("Control active in strobe.");
endmodule // mabp_props
`default_nettype wire

// [verification/mabp_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module mabp_tb_top;
	logic                 mclk = 1'b0;
	logic                 resetn = 1'b0;
	mabp_pkg::mabp_mode_t mode = mabp_pkg::MABP_MUX;
	logic                 fetch_as_read = 1'b0;
	logic                 block_select = 1'b0;
	logic [7:0]           read_low = 8'h00;
	logic [7:0]           read_high = 8'h00;
	logic                 flash_busy_in = 1'b1;
	logic                 req = 1'b0;
	logic                 req_write = 1'b0;
	logic [19:0]          req_addr = 20'h00000;
	logic [15:0]          req_data = 16'h0000;
	logic                 busy;
	logic                 done;
	logic [15:0]          rdata;
	logic [19:0]          array_address;
	logic                 array_read;
	logic                 array_write;
	logic                 array_fetch_n;
	logic                 array_generic;
	logic [7:0]           write_low;
	logic [7:0]           write_high;
	logic                 write_strobe;
	logic                 flash_abort;
	logic [7:0]           cap_low;
	logic [7:0]           cap_high;
	logic [19:0]          cap_addr;
	logic [19:0]          a;
	logic [15:0]          d;
	int                   mismatches = 0;
	int                   comparisons = 0;

	mabp_if bus ();
	mabp_host mabp_host_i (.mclk(mclk), .resetn(resetn), .bus(bus),
		.mode(mode), .fetch_as_read(fetch_as_read), .req(req),
		.req_write(req_write), .req_addr(req_addr), .req_data(req_data),
		.busy(busy), .done(done), .rdata(rdata));
	mabp_device mabp_device_i (.mclk(mclk), .resetn(resetn), .bus(bus),
		.mode(mode), .c0_kind(mabp_pkg::MABP_C0_WR_N), .ale_high(1'b1),
		.block_select(block_select), .read_low(read_low),
		.read_high(read_high), .flash_busy_in(flash_busy_in),
		.array_address(array_address), .array_read(array_read),
		.array_write(array_write), .array_fetch_n(array_fetch_n),
		.array_generic(array_generic), .write_low(write_low),
		.write_high(write_high), .write_strobe(write_strobe),
		.flash_abort(flash_abort));
	mabp_props mabp_props_i (.mclk(mclk), .resetn(resetn),
		.high_byte_bus_port(bus.high_byte_bus_port),
		.low_oe_n(bus.low_oe_n), .address_strobe(bus.address_strobe),
		.control_input_first(bus.control_input_first),
		.control_input_second(bus.control_input_second),
		.dev_low_oe_n(bus.dev_low_oe_n),
		.dev_high_oe_n(bus.dev_high_oe_n));

	always #2 mclk = ~mclk;

	// The strobe is a single pulse, so it is caught here as it passes.
	always @(posedge mclk)
		if (write_strobe === 1'b1)
		begin
			cap_low <= write_low;
			cap_high <= write_high;
			cap_addr <= array_address;
		end

	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [19:0] exp_addr(input logic [19:0] v);
		if (mode == mabp_pkg::MABP_BURST)
			return {v[19:4], 4'h0};
		return {4'h0, v[15:0]};
	endfunction

	// The no-mux host keeps its address on the low port all through.
	function automatic logic [7:0] exp_low(input logic [7:0] dat);
		if (mode == mabp_pkg::MABP_NOMUX)
			return a[7:0];
		return dat;
	endfunction

	// Only page mode moves data on the high port; else it holds address.
	function automatic logic [7:0] exp_high(input logic [7:0] dat);
		if (mode == mabp_pkg::MABP_PAGE)
			return dat;
		if (mode == mabp_pkg::MABP_BURST)
			return a[19:12];
		return a[15:8];
	endfunction

	task automatic xfer(input logic wr);
		@(posedge mclk);
		#1;
		req = 1'b1;
		req_write = wr;
		req_addr = a;
		req_data = d;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge mclk);
			#1;
			if (busy === 1'b1)
				req = 1'b0;
			if (done === 1'b1)
				return;
		end
		mismatches++;
		$display("MISMATCH %0t no done", $time);
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		void'($urandom(32'h156D));
		repeat (8) @(posedge mclk);
		#1;
		resetn = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check(20'(flash_abort), 20'h1);
		flash_busy_in = 1'b0;
		repeat (5) @(posedge mclk);
		check(20'(flash_abort), 20'h0);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge mclk);
			#1;
			resetn = 1'b0;
			mode = mabp_pkg::mabp_mode_t'(4'h1 << m);
			fetch_as_read = 1'($urandom);
			repeat (2) @(posedge mclk);
			#1;
			resetn = 1'b1;
			for (int i = 0; i < 4; i++)
			begin
				a = (i == 0) ? 20'hFFFFF : 20'($urandom);
				d = 16'($urandom);
				xfer(1'b1);
				check(20'(array_write), 20'h1);
				repeat (6) @(posedge mclk);
				#1;
				check(20'(cap_low), 20'(exp_low(d[7:0])));
				check(cap_addr, exp_addr(a));
				check(array_address, exp_addr(a));
				check(20'(cap_high),
					(mode == mabp_pkg::MABP_PAGE) ? 20'(d[15:8]) : 20'h0);
				block_select = (i != 1);
				read_low = 8'($urandom);
				read_high = 8'($urandom);
				xfer(1'b0);
				check(20'(array_read), 20'h1);
				check(20'(array_fetch_n), 20'(fetch_as_read));
				check(20'(array_generic), 20'(fetch_as_read));
				check(20'(rdata[7:0]),
					20'(exp_low(block_select ? read_low : 8'h00)));
				check(20'(rdata[15:8]),
					20'(exp_high(block_select ? read_high : 8'h00)));
			end
		end
		finish_test();
	end

	// Bounds the run well beyond the longest expected sequence.
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		finish_test();
	end
endmodule // mabp_tb_top
`default_nettype wire
